// ---- inc/bus_port_map.vh ----
// constants for the quad channel host bus port
`ifndef BUS_PORT_MAP_VH
`define BUS_PORT_MAP_VH
`define CHAN_COUNT          4
`define CHAN_A              2'h0
`define CHAN_B              2'h1
`define CHAN_C              2'h2
`define CHAN_D              2'h3
`define IRQ_ENABLE_BIT      3
`define IRQ_ENABLE_RESET    1'h0
`define IRQ_REQ_RESET       1'h0
`define READY_N_RESET       1'h1
`define MODE_STROBE         1'h1
`define MODE_SINGLE_LINE    1'h0
`define SYNC_RESET_VALUE    2'h0
`endif

// ---- logic/sync_two_ff.v ----
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sync_two_ff #(
    parameter WIDTH = 1,
    parameter [0:0] RESET_VAL = 1'h0
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // data
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // first stage read only by second stage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {WIDTH{RESET_VAL}};
            sync_r <= {WIDTH{RESET_VAL}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule

// ---- logic/bus_port_pins.v ----
// select decode, interrupt pin routing and ready merging for four channels
`timescale 1ns/1ps
`include "bus_port_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - bus_mode_pin high picks strobe bus, low picks single read/write-line bus.
// - strobe mode: select A enables channel A; single-line: the device select.
// - strobe mode: selects B, C, D enable channels B, C, D.
// - single-line mode: select B pin is address bit 3.
// - single-line mode: select C pin is address bit 4.
// - strobe mode: interrupt A driven only while its modem control bit 3 is one.
// - strobe mode: bit 3 zero floats interrupt A; zero is the default.
// - single-line mode: interrupt A is active-low open-drain device interrupt.
// - strobe mode: interrupts B, C, D driven when their bit 3 is one, else float.
// - single-line mode: interrupts B, C, D held low.
// - combined transmit ready low output is AND of four channel ready lows.
module bus_port_pins (
    // clock and reset
    input  wire       clk,
    input  wire       resetn,
    // host bus pins
    input  wire       bus_mode_pin,
    input  wire       chan_a_select_n,
    input  wire       chan_b_select_n,
    input  wire       chan_c_select_n,
    input  wire       chan_d_select_n,
    // per-channel status from the channels
    input  wire [3:0] chan_irq,
    input  wire [3:0] chan_tx_ready_n,
    input  wire [3:0] chan_rx_ready_n,
    input  wire [3:0] irq_out_enable,
    // decoded channel enables to the channels, active high
    output reg  [3:0] chan_access,
    output reg        strobe_mode,
    // interrupt pins, each output and active-low output enable
    output reg        chan_a_interrupt,
    output reg        chan_a_interrupt_oe_n,
    output reg        chan_b_interrupt,
    output reg        chan_b_interrupt_oe_n,
    output reg        chan_c_interrupt,
    output reg        chan_c_interrupt_oe_n,
    output reg        chan_d_interrupt,
    output reg        chan_d_interrupt_oe_n,
    // merged ready pins
    output reg        combined_tx_ready_n,
    output reg        combined_rx_ready_n
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    // reset release pair
    reg        rst_meta_r;
    reg        rst_n_r;
    // synchronised pins and channel status
    wire [4:0] pins_s;
    wire [3:0] irq_s;
    wire [3:0] txr_s;
    wire [3:0] rxr_s;
    wire [3:0] en_s;

    // latency: two synchroniser stages plus the output register
    // pin change shows on the outputs at the third clock edge
    // enables and requests pass the same stages, so they stay aligned
    // a live mode change settles within the same three edges

    // reset released through two flops
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'h0;
            rst_n_r    <= 1'h0;
        end else begin
            rst_meta_r <= 1'h1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // selects idle high
    sync_two_ff #(.WIDTH(5), .RESET_VAL(1'h1)) u_sync_pins (
        .clk   (clk),
        .rst_n (rst_n_r),
        .d     ({bus_mode_pin, chan_d_select_n, chan_c_select_n,
                 chan_b_select_n, chan_a_select_n}),
        .q     (pins_s)
    );

    // ready lows idle high
    sync_two_ff #(.WIDTH(8), .RESET_VAL(`READY_N_RESET)) u_sync_ready (
        .clk   (clk),
        .rst_n (rst_n_r),
        .d     ({chan_tx_ready_n, chan_rx_ready_n}),
        .q     ({txr_s, rxr_s})
    );

    // requests idle low, so no false device interrupt after reset
    sync_two_ff #(.WIDTH(4), .RESET_VAL(`IRQ_REQ_RESET)) u_sync_irq (
        .clk   (clk),
        .rst_n (rst_n_r),
        .d     (chan_irq),
        .q     (irq_s)
    );

    // modem control bit 3 copies, default zero
    sync_two_ff #(.WIDTH(4), .RESET_VAL(`IRQ_ENABLE_RESET)) u_sync_en (
        .clk   (clk),
        .rst_n (rst_n_r),
        .d     (irq_out_enable),
        .q     (en_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // select decode

    // one-hot channel from address bits 4:3
    function [3:0] chan_onehot;
        input [1:0] sel;
        begin
            chan_onehot = 4'h1 << sel;
        end
    endfunction

    // mode pin and single-line address bits after synchronising
    wire       mode_strobe = (pins_s[4] == `MODE_STROBE);
    wire       dev_select  = ~pins_s[0];
    wire [1:0] chan_addr   = {pins_s[2], pins_s[1]};
    reg  [3:0] access_nxt;

    // chip select meaning follows mode; select D unused in single-line mode
    always @* begin
        if (mode_strobe) begin
            access_nxt = ~pins_s[3:0];
        end else if (dev_select) begin
            access_nxt = chan_onehot(chan_addr);
        end else begin
            access_nxt = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt routing and ready merge

    // pin enable from a channel's modem control bit 3, active low
    function irq_drive_n;
        input enable;
        begin
            irq_drive_n = ~enable;
        end
    endfunction

    // channel enables and mode flag
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            chan_access <= 4'h0;
            strobe_mode <= `MODE_STROBE;
        end else begin
            chan_access <= access_nxt;
            strobe_mode <= mode_strobe;
        end
    end

    // channel A pin: gated channel interrupt or open-drain device interrupt
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            chan_a_interrupt      <= 1'h0;
            chan_a_interrupt_oe_n <= 1'h1;
        end else if (mode_strobe) begin
            chan_a_interrupt      <= irq_s[0];
            chan_a_interrupt_oe_n <= irq_drive_n(en_s[0]);
        end else begin
            // open drain: pull low only while some channel asks
            chan_a_interrupt      <= 1'h0;
            chan_a_interrupt_oe_n <= ~(|irq_s);
        end
    end

    // channels B to D: gated interrupts, or held low in single-line mode
    // in strobe mode, floating pins stay floating until software sets the enable bit
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            chan_b_interrupt      <= 1'h0;
            chan_b_interrupt_oe_n <= 1'h1;
            chan_c_interrupt      <= 1'h0;
            chan_c_interrupt_oe_n <= 1'h1;
            chan_d_interrupt      <= 1'h0;
            chan_d_interrupt_oe_n <= 1'h1;
        end else if (mode_strobe) begin
            chan_b_interrupt      <= irq_s[1];
            chan_b_interrupt_oe_n <= irq_drive_n(en_s[1]);
            chan_c_interrupt      <= irq_s[2];
            chan_c_interrupt_oe_n <= irq_drive_n(en_s[2]);
            chan_d_interrupt      <= irq_s[3];
            chan_d_interrupt_oe_n <= irq_drive_n(en_s[3]);
        end else begin
            // unused pins driven to a steady low
            chan_b_interrupt      <= 1'h0;
            chan_b_interrupt_oe_n <= 1'h0;
            chan_c_interrupt      <= 1'h0;
            chan_c_interrupt_oe_n <= 1'h0;
            chan_d_interrupt      <= 1'h0;
            chan_d_interrupt_oe_n <= 1'h0;
        end
    end

    // merged transmit ready: low while any channel is ready
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            combined_tx_ready_n <= `READY_N_RESET;
        end else begin
            combined_tx_ready_n <= &txr_s;
        end
    end

    // merged receive ready: low while any channel is ready
    always @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            combined_rx_ready_n <= `READY_N_RESET;
        end else begin
            combined_rx_ready_n <= &rxr_s;
        end
    end

endmodule

// ---- tb/host_model.sv ----
// host side model driving the mode and select pins
`timescale 1ns/1ps
module host_model (
    // clock
    input  wire       clk,
    // wanted pin levels from the bench
    input  wire       want_strobe,
    input  wire [3:0] want_sel,
    // pins toward the block
    output reg        bus_mode_pin = 1'h1,
    output reg  [3:0] sel_n = 4'hf
);
    // pins move on the falling edge; select D tied high in single-line mode
    always @(negedge clk) begin
        bus_mode_pin <= want_strobe;
        sel_n <= want_strobe ? want_sel : {1'h1, want_sel[2:0]};
    end
endmodule

// ---- tb/bus_port_pins_assertions.sv ----
// concurrent checks on the host bus port pins
`timescale 1ns/1ps
module port_checker (
    // clock and reset
    input wire       clk,
    input wire       resetn,
    // host bus pins
    input wire       bus_mode_pin,
    input wire       chan_a_select_n,
    input wire       chan_b_select_n,
    input wire       chan_c_select_n,
    input wire       chan_d_select_n,
    // per-channel status
    input wire [3:0] chan_irq,
    input wire [3:0] chan_tx_ready_n,
    input wire [3:0] chan_rx_ready_n,
    input wire [3:0] irq_out_enable,
    // block outputs
    input wire [3:0] chan_access,
    input wire       strobe_mode,
    input wire       chan_a_interrupt,
    input wire       chan_b_interrupt,
    input wire       chan_c_interrupt,
    input wire       chan_d_interrupt,
    input wire       chan_a_interrupt_oe_n,
    input wire       chan_b_interrupt_oe_n,
    input wire       chan_c_interrupt_oe_n,
    input wire       chan_d_interrupt_oe_n,
    input wire       combined_tx_ready_n,
    input wire       combined_rx_ready_n
);
    reg  [2:0] up_r;
    reg  [2:0] m_r;
    wire [3:0] cs_n = {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n};
    wire [3:0] iv = {chan_d_interrupt, chan_c_interrupt, chan_b_interrupt, chan_a_interrupt};
    wire [3:0] oe_n = {chan_d_interrupt_oe_n, chan_c_interrupt_oe_n, chan_b_interrupt_oe_n,
                       chan_a_interrupt_oe_n};
    wire       s = up_r == 3'h7 && m_r[2];
    wire       l = up_r == 3'h7 && !m_r[2];
    // edges since reset release, saturating, so history is past the reset
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            up_r <= 3'h0;
        else if (up_r != 3'h7)
            up_r <= up_r + 3'h1;
    end
    // mode pin three edges back
    always @(posedge clk) begin
        m_r <= {m_r[1:0], bus_mode_pin};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_mode_follow: assert property (up_r == 3'h7 |-> strobe_mode == m_r[2])
        else $error("mode lags");
    a_ready_merge: assert property (up_r == 3'h7 |-> combined_tx_ready_n ==
        &$past(chan_tx_ready_n, 3) && combined_rx_ready_n == &$past(chan_rx_ready_n, 3))
        else $error("ready merge");
    a_strobe_sel: assert property (s |-> chan_access == ~$past(cs_n, 3))
        else $error("strobe select");
    a_single_sel: assert property (l |-> chan_access ==
        ($past(cs_n[0], 3) ? 4'h0 : 4'h1 << $past(cs_n[2:1], 3))) else $error("single select");
    a_irq_a_gate: assert property (s |-> oe_n[0] == !$past(irq_out_enable[0], 3) &&
        (oe_n[0] || iv[0] == $past(chan_irq[0], 3))) else $error("irq a");
    a_irq_bcd_gate: assert property (s |-> oe_n[3:1] == ~$past(irq_out_enable[3:1], 3))
        else $error("irq bcd");
    a_irq_bcd_val: assert property (s |->
        ((iv[3:1] ^ $past(chan_irq[3:1], 3)) & ~oe_n[3:1]) == 3'h0) else $error("irq bcd value");
    a_dev_irq: assert property (l |-> !iv[0] && oe_n[0] == !$past(|chan_irq, 3))
        else $error("device irq");
    a_bcd_low: assert property (l |-> {iv[3:1], oe_n[3:1]} == 6'h00)
        else $error("bcd not low");
endmodule

// ---- tb/bus_port_pins_bench.sv ----
// self-checking bench for the host bus port pins
`timescale 1ns/1ps
module bus_port_pins_bench;
    reg        clk = 1'h0;
    reg        resetn = 1'h0;
    reg        want_strobe = 1'h1;
    reg  [3:0] want_sel = 4'hf;
    reg  [3:0] chan_irq = 4'h0;
    reg  [3:0] irq_out_enable = 4'h0;
    reg  [3:0] chan_tx_ready_n = 4'hf;
    reg  [3:0] chan_rx_ready_n = 4'hf;
    wire       bus_mode_pin, strobe_mode, combined_tx_ready_n, combined_rx_ready_n;
    wire [3:0] sel_n, chan_access, iv, oe;
    wire       dev_irq_n = oe[0] ? 1'h1 : iv[0]; // open drain with pull-up
    integer    n_mismatch = 0;
    integer    samples_checked = 0;
    integer    cycles = 0;
    integer    i;
    initial forever #10 clk = ~clk;
    host_model host (.clk, .want_strobe, .want_sel, .bus_mode_pin, .sel_n);
    bus_port_pins dut (.clk, .resetn, .bus_mode_pin, .chan_a_select_n(sel_n[0]),
        .chan_b_select_n(sel_n[1]), .chan_c_select_n(sel_n[2]), .chan_d_select_n(sel_n[3]),
        .chan_irq, .chan_tx_ready_n, .chan_rx_ready_n, .irq_out_enable, .chan_access,
        .strobe_mode, .chan_a_interrupt(iv[0]), .chan_a_interrupt_oe_n(oe[0]),
        .chan_b_interrupt(iv[1]), .chan_b_interrupt_oe_n(oe[1]), .chan_c_interrupt(iv[2]),
        .chan_c_interrupt_oe_n(oe[2]), .chan_d_interrupt(iv[3]), .chan_d_interrupt_oe_n(oe[3]),
        .combined_tx_ready_n, .combined_rx_ready_n);
    task chk(input [7:0] got, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task test_done;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // every select pattern in both bus modes, then irq routing, with the ready merge checked on every pattern
    task t_pins;
        for (i = 0; i < 96; i = i + 1) begin
            want_strobe = !(i >= 16 && i < 32) && !(i >= 64 && i < 80);
            want_sel = i[3:0];
            irq_out_enable = i < 64 ? i[3:0] : (i < 80 ? ~i[3:0] : 4'hf);
            chan_irq = i < 64 ? 4'h5 : i[3:0];
            chan_tx_ready_n = i[3:0];
            chan_rx_ready_n = ~i[3:0];
            repeat (5) @(negedge clk);
            if (want_strobe)
                chk({strobe_mode, chan_access}, {1'h1, ~i[3:0]});
            else
                chk({strobe_mode, chan_access}, i[0] ? 5'h00 : 5'h01 << i[2:1]);
            if (i >= 32 && i < 64)
                chk({oe, iv & ~oe}, {~i[3:0], 4'h5 & i[3:0]});
            if (i >= 64 && i < 80)
                chk({iv, dev_irq_n, oe[3:1]}, {4'h0, i[3:0] == 4'h0, 3'h0});
            if (i >= 80)
                chk({oe, iv}, {4'h0, i[3:0]});
            chk({combined_tx_ready_n, combined_rx_ready_n}, {&i[3:0], ~|i[3:0]});
        end
    endtask
    // mid-run reset: pins float, no access, ready lows high
    task t_reset;
        resetn = 1'h0;
        @(negedge clk);
        chk({strobe_mode, chan_access}, {1'h1, 4'h0});
        chk({oe, iv}, {4'hf, 4'h0});
        chk({combined_tx_ready_n, combined_rx_ready_n}, 2'h3);
        repeat (7) @(negedge clk);
        resetn = 1'h1;
        repeat (6) @(negedge clk);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'h1;
        repeat (6) @(negedge clk);
        t_pins;
        t_reset;
        t_pins;
        test_done;
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
endmodule
bind bus_port_pins port_checker chk_i (.clk, .resetn, .bus_mode_pin, .strobe_mode,
    .chan_a_select_n, .chan_b_select_n, .chan_c_select_n, .chan_d_select_n, .chan_irq,
    .chan_tx_ready_n, .chan_rx_ready_n, .irq_out_enable, .chan_access, .chan_a_interrupt,
    .chan_b_interrupt, .chan_c_interrupt, .chan_d_interrupt, .chan_a_interrupt_oe_n,
    .chan_b_interrupt_oe_n, .chan_c_interrupt_oe_n, .chan_d_interrupt_oe_n,
    .combined_tx_ready_n, .combined_rx_ready_n);
